// File: hdl/usc_pkg.sv
// Constants and register map of the UART shadow control block
// Functional notes
// - Break shadow and line control break bit are one flip-flop.
// - Break set, loopback off: serial output held low until break clears.
// - Break set in infrared mode: infrared output pulses while break holds.
// - Break in loopback: fed to own receiver, external output not forced.
// - DMA mode shadow mirrors FIFO control DMA bit; selects request mode.
// - FIFO enable shadow mirrors FIFO control enable; gates both FIFOs.
// - FIFO enable falling resets both FIFO controllers to empty.
// - RX trigger shadow mirrors trigger field; sets data-available threshold.
// - In DMA mode 1 the RX request follows the same RX threshold.
package usc_pkg;
    // Register byte addresses
    localparam logic [31:0] BREAK_SHADOW_ADDR = 32'h5000_1190;
    localparam logic [31:0] DMA_MODE_SHADOW_ADDR = 32'h5000_1194;
    localparam logic [31:0] FIFO_ENABLE_SHADOW_ADDR = 32'h5000_1198;
    localparam logic [31:0] RX_TRIGGER_SHADOW_ADDR = 32'h5000_119C;
    localparam logic [31:0] FIFO_CONTROL_ADDR = 32'h5000_1008;
    localparam logic [31:0] LINE_CONTROL_ADDR = 32'h5000_100C;
    localparam logic [31:0] MODEM_CONTROL_ADDR = 32'h5000_1010;
    localparam logic [31:0] INT_STATUS_ADDR = 32'h5000_1200;
    localparam logic [31:0] INT_ENABLE_ADDR = 32'h5000_1204;
    localparam logic [31:0] INT_CLEAR_ADDR = 32'h5000_1208;

    // Field positions
    localparam int LCR_BREAK_BIT = 6;
    localparam int MCR_LOOP_BIT = 4;
    localparam int MCR_SIR_BIT = 6;
    localparam int FCR_FIFO_EN_BIT = 0;
    localparam int FCR_DMA_MODE_BIT = 3;
    localparam int FCR_RX_TRIG_LSB = 6;
    localparam int FCR_RX_TRIG_MSB = 7;

    // Receive trigger codes
    localparam logic [1:0] RX_TRIG_ONE = 2'h0;
    localparam logic [1:0] RX_TRIG_HALF_A = 2'h1;
    localparam logic [1:0] RX_TRIG_HALF_B = 2'h2;
    localparam logic [1:0] RX_TRIG_FULL_M2 = 2'h3;

    // Interrupt event bits
    localparam int EV_BREAK = 0;
    localparam int EV_FLUSH = 1;
    localparam int EV_RX_AVAIL = 2;
    localparam int EV_W = 3;

    // Reset values
    localparam logic [7:0] LCR_RESET = 8'h00;
    localparam logic [6:0] MCR_RESET = 7'h00;
    localparam logic [1:0] RX_TRIG_RESET = 2'h0;
    localparam logic [EV_W-1:0] INT_RESET = 3'h0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // Timing of the infrared break pulse train
    localparam int CLK_PERIOD_NS = 8;
    localparam int SIR_PULSE_NS = 1600;
    localparam int SIR_PERIOD_NS = 8680;
    localparam int SIR_PULSE_CYC =
        (SIR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SIR_PERIOD_CYC = SIR_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SIR_CNT_W = 12;
endpackage : usc_pkg

// File: hdl/usc_fifo_if.sv
// Control and request signals between register file and DMA request logic
`timescale 1ns/1ns
interface usc_fifo_if #(
    parameter int LVL_W = 5
);
    logic fifo_en;
    logic dma_mode;
    logic [1:0] rx_trig;
    logic [LVL_W-1:0] rx_level;
    logic [LVL_W-1:0] tx_level;
    logic rx_avail;
    logic dma_rx_req_n;
    logic dma_tx_req_n;

    modport ctrl (
        output fifo_en, dma_mode, rx_trig, rx_level, tx_level,
        input rx_avail, dma_rx_req_n, dma_tx_req_n
    );
    modport req (
        input fifo_en, dma_mode, rx_trig, rx_level, tx_level,
        output rx_avail, dma_rx_req_n, dma_tx_req_n
    );
endinterface : usc_fifo_if

// File: hdl/usc_dma_req.sv
// Receive threshold, data-available flag and DMA request generation
`timescale 1ns/1ns
module usc_dma_req
    import usc_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int LVL_W = 5
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    usc_fifo_if.req fif
);
    // Thresholds assume a power-of-two depth and a level one bit wider
    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0 ||
            LVL_W != $clog2(DEPTH) + 1) begin : g_depth_check
        $error("usc_dma_req: DEPTH must be a power of two >= 4");
    end

    localparam logic [LVL_W-1:0] LVL_ONE = LVL_W'(1);
    localparam logic [LVL_W-1:0] LVL_HALF = LVL_W'(DEPTH / 2);
    localparam logic [LVL_W-1:0] LVL_FULL_M2 = LVL_W'(DEPTH - 2);
    localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(DEPTH);

    logic [LVL_W-1:0] thr;
    logic [LVL_W-1:0] dma_thr;
    logic rx_avail_q;
    logic rx_req_n_q;
    logic tx_req_n_q;

    // Trigger decode; a disabled FIFO behaves as one character deep
    always_comb begin
        thr = LVL_ONE;
        if (fif.fifo_en) begin
            unique case (fif.rx_trig)
                RX_TRIG_ONE: thr = LVL_ONE;
                RX_TRIG_HALF_A: thr = LVL_HALF;
                RX_TRIG_HALF_B: thr = LVL_HALF;
                RX_TRIG_FULL_M2: thr = LVL_FULL_M2;
            endcase
        end
        // Mode 0 asks on any character, mode 1 on the threshold
        dma_thr = (fif.dma_mode && fif.fifo_en) ? thr : LVL_ONE;
    end

    // Received data available level
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_avail_q <= 1'b0;
        end else begin
            rx_avail_q <= (fif.rx_level >= thr);
        end
    end

    // RX request holds until the FIFO drains, so bursts are not cut short
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_req_n_q <= 1'b1;
        end else if (fif.rx_level == '0) begin
            rx_req_n_q <= 1'b1;
        end else if (fif.rx_level >= dma_thr) begin
            rx_req_n_q <= 1'b0;
        end
    end

    // TX request: mode 0 only while empty, mode 1 until full
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_req_n_q <= 1'b1;
        end else if (fif.tx_level == '0) begin
            tx_req_n_q <= 1'b0;
        end else if (!(fif.dma_mode && fif.fifo_en) ||
                     fif.tx_level >= LVL_FULL) begin
            tx_req_n_q <= 1'b1;
        end
    end

    assign fif.rx_avail = rx_avail_q;
    assign fif.dma_rx_req_n = rx_req_n_q;
    assign fif.dma_tx_req_n = tx_req_n_q;
endmodule : usc_dma_req

// File: hdl/usc_shadow_ctrl.sv
// UART shadow control registers with APB slave and serial output control
`timescale 1ns/1ns
module usc_shadow_ctrl
    import usc_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int LVL_W = 5
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_tx_serial,
    input wire logic i_tx_sir_n,
    input wire logic [LVL_W-1:0] i_rx_fifo_level,
    input wire logic [LVL_W-1:0] i_tx_fifo_level,
    output logic o_sout,
    output logic o_sir_out_n,
    output logic o_loop_rx,
    output logic o_loopback,
    output logic o_fifo_enable,
    output logic o_fifo_flush,
    output logic o_dma_mode,
    output logic [1:0] o_rx_trigger,
    output logic o_rx_avail,
    output logic o_dma_rx_req_n,
    output logic o_dma_tx_req_n,
    output logic o_irq
);
    // Pulse counter is SIR_CNT_W bits; a longer period would wrap early
    if (SIR_PULSE_CYC >= SIR_PERIOD_CYC ||
            SIR_PERIOD_CYC >= (1 << SIR_CNT_W)) begin : g_sir_check
        $error("usc_shadow_ctrl: infrared pulse timing out of range");
    end

    localparam logic [SIR_CNT_W-1:0] SIR_PULSE = SIR_CNT_W'(SIR_PULSE_CYC);
    localparam logic [SIR_CNT_W-1:0] SIR_LAST =
        SIR_CNT_W'(SIR_PERIOD_CYC - 1);

    // Control bundle shared with the DMA request logic
    usc_fifo_if #(.LVL_W(LVL_W)) fif ();

    // Control state
    logic [7:0] lcr_q;
    logic [6:0] mcr_q;
    logic fifo_en_q;
    logic dma_mode_q;
    logic [1:0] rx_trig_q;
    logic [EV_W-1:0] int_stat_q;
    logic [EV_W-1:0] int_en_q;
    logic irq_q;

    // Bus side
    logic setup;
    logic wr_acc;
    logic [31:0] rdata_d;
    logic hit;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // Serial side
    logic [SIR_CNT_W-1:0] sir_cnt_q;
    logic sir_pulse;
    logic sout_q;
    logic sir_q;
    logic loop_rx_q;
    logic flush_q;
    logic break_d1_q;
    logic avail_d1_q;
    logic [EV_W-1:0] ev;

    // Control fields the serial side acts on
    wire brk = lcr_q[LCR_BREAK_BIT];
    wire loop_en = mcr_q[MCR_LOOP_BIT];
    wire sir_en = mcr_q[MCR_SIR_BIT];

    // Setup phase latches the answer; the write lands in the access phase
    assign setup = i_psel && !i_penable;
    assign wr_acc = i_psel && i_penable && pready_q && i_pwrite && !pslverr_q;

    // Read mux over live fields, so either write path shows at once
    always_comb begin
        rdata_d = RDATA_RESET;
        hit = 1'b1;
        unique case (i_paddr)
            BREAK_SHADOW_ADDR: rdata_d[0] = brk;
            DMA_MODE_SHADOW_ADDR: rdata_d[0] = dma_mode_q;
            FIFO_ENABLE_SHADOW_ADDR: rdata_d[0] = fifo_en_q;
            RX_TRIGGER_SHADOW_ADDR: rdata_d[1:0] = rx_trig_q;
            LINE_CONTROL_ADDR: rdata_d[7:0] = lcr_q;
            MODEM_CONTROL_ADDR: rdata_d[6:0] = mcr_q;
            FIFO_CONTROL_ADDR: begin
                rdata_d[FCR_FIFO_EN_BIT] = fifo_en_q;
                rdata_d[FCR_DMA_MODE_BIT] = dma_mode_q;
                rdata_d[FCR_RX_TRIG_MSB:FCR_RX_TRIG_LSB] = rx_trig_q;
            end
            INT_STATUS_ADDR: rdata_d[EV_W-1:0] = int_stat_q;
            INT_ENABLE_ADDR: rdata_d[EV_W-1:0] = int_en_q;
            INT_CLEAR_ADDR: rdata_d = RDATA_RESET;
            default: hit = 1'b0;
        endcase
    end

    // APB answer: ready in the first access cycle, error on unmapped
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            prdata_q <= RDATA_RESET;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= i_pwrite ? RDATA_RESET : rdata_d;
            pready_q <= 1'b1;
            pslverr_q <= !hit;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Line control; its break bit is the break shadow itself
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            lcr_q <= LCR_RESET;
        end else if (wr_acc && i_paddr == LINE_CONTROL_ADDR) begin
            lcr_q <= i_pwdata[7:0];
        end else if (wr_acc && i_paddr == BREAK_SHADOW_ADDR) begin
            lcr_q[LCR_BREAK_BIT] <= i_pwdata[0];
        end
    end

    // Modem control: loopback and infrared mode
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            mcr_q <= MCR_RESET;
        end else if (wr_acc && i_paddr == MODEM_CONTROL_ADDR) begin
            mcr_q <= i_pwdata[6:0];
        end
    end

    // FIFO enable from the control register or its shadow
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            fifo_en_q <= 1'b0;
        end else if (wr_acc && i_paddr == FIFO_CONTROL_ADDR) begin
            fifo_en_q <= i_pwdata[FCR_FIFO_EN_BIT];
        end else if (wr_acc && i_paddr == FIFO_ENABLE_SHADOW_ADDR) begin
            fifo_en_q <= i_pwdata[0];
        end
    end

    // DMA mode from the control register or its shadow
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            dma_mode_q <= 1'b0;
        end else if (wr_acc && i_paddr == FIFO_CONTROL_ADDR) begin
            dma_mode_q <= i_pwdata[FCR_DMA_MODE_BIT];
        end else if (wr_acc && i_paddr == DMA_MODE_SHADOW_ADDR) begin
            dma_mode_q <= i_pwdata[0];
        end
    end

    // Receive trigger from the control register or its shadow
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_trig_q <= RX_TRIG_RESET;
        end else if (wr_acc && i_paddr == FIFO_CONTROL_ADDR) begin
            rx_trig_q <= i_pwdata[FCR_RX_TRIG_MSB:FCR_RX_TRIG_LSB];
        end else if (wr_acc && i_paddr == RX_TRIGGER_SHADOW_ADDR) begin
            rx_trig_q <= i_pwdata[1:0];
        end
    end

    // One-cycle flush of both FIFO controllers on enable falling
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= o_fifo_enable && !fifo_en_q;
        end
    end

    // Infrared pulse divider; free runs only while a break is sent
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            sir_cnt_q <= '0;
        end else if (!(brk && sir_en) || sir_cnt_q == SIR_LAST) begin
            sir_cnt_q <= '0;
        end else begin
            sir_cnt_q <= sir_cnt_q + 1'b1;
        end
    end
    // Low part of each period drives the infrared pulse
    assign sir_pulse = sir_cnt_q < SIR_PULSE;

    // Serial outputs; loopback keeps the line marking, break goes inside
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            sout_q <= 1'b1;
            sir_q <= 1'b1;
            loop_rx_q <= 1'b1;
        end else if (loop_en) begin
            sout_q <= 1'b1;
            sir_q <= 1'b1;
            loop_rx_q <= brk ? 1'b0 : i_tx_serial;
        end else begin
            sout_q <= brk ? 1'b0 : i_tx_serial;
            sir_q <= (brk && sir_en) ? !sir_pulse : i_tx_sir_n;
            loop_rx_q <= 1'b1;
        end
    end

    // Event edges for the interrupt block
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            break_d1_q <= 1'b0;
            avail_d1_q <= 1'b0;
        end else begin
            break_d1_q <= brk;
            avail_d1_q <= fif.rx_avail;
        end
    end

    // One-cycle event strobes toward the sticky status
    always_comb begin
        ev = '0;
        ev[EV_BREAK] = brk && !break_d1_q;
        ev[EV_FLUSH] = flush_q;
        ev[EV_RX_AVAIL] = fif.rx_avail && !avail_d1_q;
    end

    // Sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            int_stat_q <= INT_RESET;
        end else if (wr_acc && i_paddr == INT_CLEAR_ADDR) begin
            int_stat_q <= (int_stat_q & ~i_pwdata[EV_W-1:0]) | ev;
        end else begin
            int_stat_q <= int_stat_q | ev;
        end
    end

    // Interrupt enable and level output
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            int_en_q <= INT_RESET;
            irq_q <= 1'b0;
        end else begin
            if (wr_acc && i_paddr == INT_ENABLE_ADDR) begin
                int_en_q <= i_pwdata[EV_W-1:0];
            end
            irq_q <= |(int_stat_q & int_en_q);
        end
    end

    // Shadowed controls toward the FIFO and DMA logic
    assign fif.fifo_en = fifo_en_q;
    assign fif.dma_mode = dma_mode_q;
    assign fif.rx_trig = rx_trig_q;
    assign fif.rx_level = i_rx_fifo_level;
    assign fif.tx_level = i_tx_fifo_level;

    usc_dma_req #(
        .DEPTH(DEPTH),
        .LVL_W(LVL_W)
    ) u_dma_req (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .fif(fif.req)
    );

    // Outputs, each straight from a flip-flop
    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_sout = sout_q;
    assign o_sir_out_n = sir_q;
    assign o_loop_rx = loop_rx_q;
    assign o_loopback = mcr_q[MCR_LOOP_BIT];
    assign o_fifo_flush = flush_q;
    assign o_dma_mode = dma_mode_q;
    assign o_rx_trigger = rx_trig_q;
    assign o_rx_avail = fif.rx_avail;
    assign o_dma_rx_req_n = fif.dma_rx_req_n;
    assign o_dma_tx_req_n = fif.dma_tx_req_n;
    assign o_irq = irq_q;

    // Enable output register, also the previous value for the flush edge
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_fifo_enable <= 1'b0;
        end else begin
            o_fifo_enable <= fifo_en_q;
        end
    end
endmodule : usc_shadow_ctrl

// File: tb/usc_shadow_ctrl_monitor.sv
// Port-level assertions for the UART shadow control block
`timescale 1ns/1ns
module usc_shadow_ctrl_monitor #(
    parameter int DEPTH = 16,
    parameter int LVL_W = 5
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [LVL_W-1:0] i_rx_fifo_level,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_sout,
    input wire logic o_sir_out_n,
    input wire logic o_loopback,
    input wire logic o_fifo_enable,
    input wire logic o_fifo_flush,
    input wire logic o_dma_mode,
    input wire logic [1:0] o_rx_trigger,
    input wire logic o_rx_avail,
    input wire logic o_dma_rx_req_n
);
    localparam int THR_FULL = DEPTH - 2;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    // Guards below wait one cycle so mirror lag never matters
    property p_ready_after_setup;
        i_psel && !i_penable |=> o_pready;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("ready missing after setup");
    property p_ready_pulse;
        o_pready |=> !o_pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready longer than one cycle");
    property p_err_with_ready;
        o_pslverr |-> o_pready && i_psel && i_penable;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("error outside an access");
    property p_flush_on_fall;
        $fell(o_fifo_enable) |-> o_fifo_flush;
    endproperty
    a_flush_on_fall: assert property (p_flush_on_fall)
        else $error("no flush when fifo disabled");
    property p_flush_pulse;
        o_fifo_flush |-> !o_fifo_enable ##1 !o_fifo_flush;
    endproperty
    a_flush_pulse: assert property (p_flush_pulse)
        else $error("flush not a single pulse");
    property p_loop_quiet;
        o_loopback && $past(o_loopback) |-> o_sout && o_sir_out_n;
    endproperty
    a_loop_quiet: assert property (p_loop_quiet)
        else $error("line driven during loopback");
    property p_avail_nofifo;
        !o_fifo_enable |-> o_rx_avail == ($past(i_rx_fifo_level) != 0);
    endproperty
    a_avail_nofifo: assert property (p_avail_nofifo)
        else $error("fifo off threshold not one");
    property p_avail_full;
        o_fifo_enable && $past(o_fifo_enable) && o_rx_trigger == 2'h3
        && $past(o_rx_trigger) == 2'h3
        |-> o_rx_avail == ($past(i_rx_fifo_level) >= THR_FULL);
    endproperty
    a_avail_full: assert property (p_avail_full)
        else $error("full threshold wrong");
    property p_rx_req_hold;
        o_dma_mode && $past(o_dma_mode) && o_fifo_enable
        && $past(o_fifo_enable) && o_rx_trigger == 2'h3
        && $past(o_rx_trigger) == 2'h3 && $past(o_dma_rx_req_n)
        && $past(i_rx_fifo_level) < THR_FULL |-> o_dma_rx_req_n;
    endproperty
    a_rx_req_hold: assert property (p_rx_req_hold)
        else $error("rx request below threshold");
endmodule : usc_shadow_ctrl_monitor

bind usc_shadow_ctrl usc_shadow_ctrl_monitor #(
    .DEPTH(DEPTH),
    .LVL_W(LVL_W)
) u_mon (.i_mclk, .i_nrst, .i_psel, .i_penable, .i_rx_fifo_level,
    .o_pready, .o_pslverr, .o_sout, .o_sir_out_n, .o_loopback,
    .o_fifo_enable, .o_fifo_flush, .o_dma_mode, .o_rx_trigger,
    .o_rx_avail, .o_dma_rx_req_n);

// File: tb/usc_line_model.sv
// Remote serial receiver watching both transmit lines
`timescale 1ns/1ns
module usc_line_model #(
    parameter int BREAK_CYC = 16
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_sout,
    input wire logic i_sir_n,
    input wire logic i_clr,
    output logic o_break_seen,
    output logic [15:0] o_sir_lows
);
    logic [15:0] space_q;
    // A long space reads as break; any mark restarts it
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            space_q <= '0;
            o_sir_lows <= '0;
        end else begin
            space_q <= i_sout ? 16'h0000 : space_q + 16'h0001;
            o_sir_lows <= i_clr ? 16'h0000 : o_sir_lows + 16'(!i_sir_n);
        end
    end
    assign o_break_seen = (space_q >= 16'(BREAK_CYC));
endmodule : usc_line_model

// File: tb/usc_shadow_ctrl_test.sv
// Self-checking bench for the UART shadow control block
`timescale 1ns/1ns
module usc_shadow_ctrl_test
    import usc_pkg::*;
;
    localparam int DEPTH = 16;
    localparam int LVL_W = 5;
    logic i_mclk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [31:0] i_paddr = '0, i_pwdata = '0, o_prdata, line_control_reg, fifo_control_reg;
    logic i_tx_serial = 1'b1, i_tx_sir_n = 1'b1, prev_tx, txrand = 1'b0;
    logic [LVL_W-1:0] i_rx_fifo_level = '0, i_tx_fifo_level = '0;
    logic o_pready, o_pslverr, o_sout, o_sir_out_n, o_loop_rx, o_loopback;
    logic o_fifo_enable, o_fifo_flush, o_dma_mode, o_rx_avail, o_irq;
    logic o_dma_rx_req_n, o_dma_tx_req_n, clr = 1'b0, brk_seen;
    logic [1:0] o_rx_trigger;
    logic [15:0] sir_lows;
    logic [32:0] exp_q[$];
    int n_fail = 0, tests_run = 0, flushes = 0, f0, thr;

    always #4 i_mclk = ~i_mclk;
    usc_shadow_ctrl #(.DEPTH(DEPTH), .LVL_W(LVL_W)) dut_u (.i_mclk,
        .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .o_prdata, .o_pready, .o_pslverr, .i_tx_serial, .i_tx_sir_n,
        .i_rx_fifo_level, .i_tx_fifo_level, .o_sout, .o_sir_out_n,
        .o_loop_rx, .o_loopback, .o_fifo_enable, .o_fifo_flush,
        .o_dma_mode, .o_rx_trigger, .o_rx_avail, .o_dma_rx_req_n,
        .o_dma_tx_req_n, .o_irq);
    usc_line_model #(.BREAK_CYC(16)) far_u (.i_mclk, .i_nrst,
        .i_sout(o_sout), .i_sir_n(o_sir_out_n), .i_clr(clr),
        .o_break_seen(brk_seen), .o_sir_lows(sir_lows));

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input string nm, input logic [32:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // Request held until ready is sampled; idle cycle keeps drives apart
    task automatic apb(input logic wr, input logic [31:0] a, d);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        // No wait count assumed; only the watchdog ends a hung access
        do begin
            @(posedge i_mclk);
        end while (o_pready !== 1'b1);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_mclk);
    endtask : apb
    task automatic rd(input logic [31:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd
    task automatic lvl(input int v);
        i_rx_fifo_level <= LVL_W'(v);
        repeat (3) @(posedge i_mclk);
    endtask : lvl
    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask : done

    // Read answers checked against the oldest note
    always @(posedge i_mclk) begin
        if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1) begin
            if (exp_q.size() > 0) begin
                check("read", {o_pslverr, o_prdata}, exp_q.pop_front());
            end
        end
    end
    // Random core bits; flush pulses counted
    always @(posedge i_mclk) begin
        prev_tx <= i_tx_serial;
        if (txrand) i_tx_serial <= 1'($urandom);
        if (o_fifo_flush === 1'b1) flushes++;
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        n_fail++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h7376));
        repeat (10) @(posedge i_mclk);
        i_nrst <= 1'b1;
        @(posedge i_mclk);
        rd(BREAK_SHADOW_ADDR, 33'h0_0000_0000);
        rd(DMA_MODE_SHADOW_ADDR, 33'h0_0000_0000);
        rd(FIFO_ENABLE_SHADOW_ADDR, 33'h0_0000_0000);
        rd(RX_TRIGGER_SHADOW_ADDR, 33'h0_0000_0000);
        rd(32'h5000_1300, 33'h1_0000_0000);
        done("reset");
        line_control_reg = ($urandom & 32'h0000_003F) | 32'h0000_0040;
        apb(1'b1, LINE_CONTROL_ADDR, line_control_reg);
        txrand = 1'b1;
        rd(BREAK_SHADOW_ADDR, 33'h0_0000_0001);
        repeat (20) @(posedge i_mclk);
        check("sout", o_sout, 1'b0);
        check("break seen", brk_seen, 1'b1);
        apb(1'b1, BREAK_SHADOW_ADDR, 32'h0000_0000);
        rd(LINE_CONTROL_ADDR, {1'b0, line_control_reg & 32'h0000_00BF});
        repeat (8) begin
            @(posedge i_mclk);
            check("sout", o_sout, prev_tx);
        end
        done("break");
        apb(1'b1, MODEM_CONTROL_ADDR, 32'h0000_0040);
        apb(1'b1, BREAK_SHADOW_ADDR, 32'h0000_0001);
        repeat (SIR_PERIOD_CYC) @(posedge i_mclk);
        clr <= 1'b1;
        @(posedge i_mclk);
        clr <= 1'b0;
        repeat (SIR_PERIOD_CYC + 1) @(posedge i_mclk);
        check("sir lows", sir_lows, SIR_PULSE_CYC);
        apb(1'b1, MODEM_CONTROL_ADDR, 32'h0000_0010);
        repeat (3) @(posedge i_mclk);
        check("loop sout", o_sout, 1'b1);
        check("loop rx", o_loop_rx, 1'b0);
        apb(1'b1, MODEM_CONTROL_ADDR, 32'h0000_0000);
        apb(1'b1, BREAK_SHADOW_ADDR, 32'h0000_0000);
        done("infrared and loopback");
        // Every trigger code, DMA mode 1, edges of each threshold
        for (int c = 0; c < 4; c++) begin
            fifo_control_reg = {24'h00_0000, c[1:0], 6'h09};
            apb(1'b1, FIFO_CONTROL_ADDR, fifo_control_reg);
            rd(RX_TRIGGER_SHADOW_ADDR, {31'h0000_0000, c[1:0]});
            rd(DMA_MODE_SHADOW_ADDR, 33'h0_0000_0001);
            rd(FIFO_ENABLE_SHADOW_ADDR, 33'h0_0000_0001);
            thr = (c == 0) ? 1 : (c == 3) ? DEPTH - 2 : DEPTH / 2;
            lvl(thr - 1);
            check("avail", o_rx_avail, 1'b0);
            check("rx req", o_dma_rx_req_n, 1'b1);
            lvl(thr);
            check("avail", o_rx_avail, 1'b1);
            check("rx req", o_dma_rx_req_n, 1'b0);
            lvl(0);
        end
        apb(1'b1, RX_TRIGGER_SHADOW_ADDR, 32'h0000_0002);
        apb(1'b1, DMA_MODE_SHADOW_ADDR, 32'h0000_0000);
        rd(FIFO_CONTROL_ADDR, 33'h0_0000_0081);
        lvl(1);
        check("mode0 rx req", o_dma_rx_req_n, 1'b0);
        lvl(0);
        check("tx req", o_dma_tx_req_n, 1'b0);
        apb(1'b1, DMA_MODE_SHADOW_ADDR, 32'h0000_0001);
        i_tx_fifo_level <= LVL_W'(DEPTH);
        repeat (3) @(posedge i_mclk);
        check("mode1 tx req", o_dma_tx_req_n, 1'b1);
        i_tx_fifo_level <= '0;
        done("fifo fields");
        // Disable fifo: one flush, event raises the enabled interrupt
        apb(1'b1, INT_CLEAR_ADDR, 32'h0000_0007);
        apb(1'b1, INT_ENABLE_ADDR, 32'h0000_0002);
        f0 = flushes;
        apb(1'b1, FIFO_ENABLE_SHADOW_ADDR, 32'h0000_0000);
        repeat (3) @(posedge i_mclk);
        check("flushes", flushes - f0, 1);
        check("irq", o_irq, 1'b1);
        rd(INT_STATUS_ADDR, 33'h0_0000_0002);
        lvl(1);
        check("fifo off avail", o_rx_avail, 1'b1);
        lvl(0);
        apb(1'b1, INT_ENABLE_ADDR, 32'h0000_0000);
        repeat (3) @(posedge i_mclk);
        check("masked irq", o_irq, 1'b0);
        apb(1'b1, INT_CLEAR_ADDR, 32'h0000_0007);
        rd(INT_STATUS_ADDR, 33'h0_0000_0000);
        rd(INT_CLEAR_ADDR, 33'h0_0000_0000);
        done("flush and interrupt");
        print_verdict();
    end
endmodule : usc_shadow_ctrl_test
